// *** rtl/adc_cmd_pkg.sv ***
// package: register map, reset values and carriers of the command register bank
package adc_cmd_pkg;

  // --------------------------------------------------------------------------
  // register indices (byte address is four times the index)
  // --------------------------------------------------------------------------
  localparam logic [5:0] IDX_FLAG_CLEAR  = 6'h1a;
  localparam logic [5:0] IDX_CAL_MASK    = 6'h1c;
  localparam logic [5:0] IDX_CAL_CONFIG  = 6'h1e;
  localparam logic [5:0] IDX_BOARD_RESET = 6'h20;
  localparam logic [5:0] IDX_CAL_START   = 6'h22;
  localparam logic [5:0] IDX_SCAN_ABORT  = 6'h2a;
  localparam logic [5:0] IDX_STATUS      = 6'h30;

  // --------------------------------------------------------------------------
  // field positions and reset values
  // --------------------------------------------------------------------------
  localparam int          CMD_BIT        = 0;
  localparam logic [15:0] CAL_MASK_RST   = 16'h0000;
  localparam logic [7:0]  CAL_CONFIG_RST = 8'h00;
  localparam logic        CMD_RST        = 1'b0;
  localparam int          ST_DATA_READY  = 0;
  localparam int          ST_CFG_DONE    = 1;
  localparam int          ST_SCAN_ACTIVE = 2;
  localparam int          ST_CAL_BUSY    = 3;

  // --------------------------------------------------------------------------
  // command slots
  // --------------------------------------------------------------------------
  localparam int CMD_N   = 4;
  localparam int CMD_CLR = 0;
  localparam int CMD_BRS = 1;
  localparam int CMD_CAL = 2;
  localparam int CMD_ABT = 3;
  localparam logic [5:0] CMD_IDX [CMD_N] = '{IDX_FLAG_CLEAR, IDX_BOARD_RESET,
                                            IDX_CAL_START, IDX_SCAN_ABORT};

  // --------------------------------------------------------------------------
  // bus answers
  // --------------------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // cutoff[3..0] = 1 Hz, 10 Hz, 100 Hz, 1 kHz; range[3..0] = 10 mV, 100 mV, 1 V, 10 V
  typedef struct packed {
    logic [3:0] cutoff;
    logic [3:0] range;
  } cal_config_type;

  typedef struct packed {
    logic data_ready;
    logic config_complete;
    logic scan_active;
    logic reset_done;
    logic cal_done;
    logic abort_done;
  } board_event_type;

  typedef enum logic [1:0] {CAL_IDLE, CAL_HELD, CAL_RUN} cal_state_type;

endpackage

// *** rtl/cmd_pending_bit.sv ***
// one self-clearing command bit: set by software, cleared when its action is done
`timescale 1ns/1ps
module cmd_pending_bit
  import adc_cmd_pkg::*;
(
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // control
  input  wire logic set,
  input  wire logic done,
  // state
  output logic      pending
);

  logic pending_ff;
  logic nxt_pending;

  // set wins over done, so a fresh command in the finishing cycle survives
  always_comb begin
    nxt_pending = set | (pending_ff & ~done); // RQ15
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pending_ff <= CMD_RST;
    end else begin
      pending_ff <= nxt_pending;
    end
  end

  assign pending = pending_ff;

endmodule

// *** rtl/adc_board_command_registers.sv ***
// command and calibration-setup register bank behind an AXI4-Lite slave
`timescale 1ns/1ps
// Summary of operation
// RQ1 - Writing one to bit 0 of the flag clear register asks the board to clear data-ready and config-complete.
// RQ2 - The flag clear bit falls back to zero only once both flags read low.
// RQ3 - Software writes zero to all reserved command and config bits.
// RQ4 - Mask bit x set puts channel x into the next calibration.
// RQ5 - The channel mask and the config select come out of reset as zero.
// RQ6 - Config bits 7 to 4 pick the 1 Hz, 10 Hz, 100 Hz and 1 kHz cutoffs for calibration.
// RQ7 - Config bits 3 to 0 pick the 10 mV, 100 mV, 1 V and 10 V ranges for calibration.
// RQ8 - A board without filters is set up by software with bits 7 to 5 low and bit 4 high.
// RQ9 - Writing one to the board reset bit runs the reset and returns the setup registers to default.
// RQ10 - The board reset bit clears only when the reset sequence reports done.
// RQ11 - Writing one to the calibration bit calibrates the masked channels with the chosen setup.
// RQ12 - The calibration bit returns to zero when calibration finishes.
// RQ13 - A calibration command waits while a scan is active until the scan is aborted.
// RQ14 - Writing one to the scan abort bit aborts the scan and the bit clears once it is aborted.
// RQ15 - A command bit reads one while pending and writing zero to it does nothing.
module adc_board_command_registers
  import adc_cmd_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input  wire logic          aclk,
  input  wire logic          aresetn,
  // axi4-lite write
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic          awvalid,
  output logic               awready,
  input  wire logic [31:0]   wdata,
  input  wire logic [3:0]    wstrb,
  input  wire logic          wvalid,
  output logic               wready,
  output logic [1:0]         bresp,
  output logic               bvalid,
  input  wire logic          bready,
  // axi4-lite read
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic          arvalid,
  output logic               arready,
  output logic [31:0]        rdata,
  output logic [1:0]         rresp,
  output logic               rvalid,
  input  wire logic          rready,
  // board status and completions
  input  board_event_type    board_in,
  // board requests
  output logic               flag_clear_req,
  output logic               board_reset_req,
  output logic               scan_abort_req,
  output logic               cal_start,
  output logic               cal_busy,
  output logic [15:0]        cal_channels,
  output cal_config_type     cal_setup
);

  // --------------------------------------------------------------------------
  // declarations
  // --------------------------------------------------------------------------
  logic              awready_ff, nxt_awready;
  logic              wready_ff, nxt_wready;
  logic              bvalid_ff, nxt_bvalid;
  logic [1:0]        bresp_ff, nxt_bresp;
  logic              aw_got_ff, nxt_aw_got;
  logic              w_got_ff, nxt_w_got;
  logic [ADDR_W-1:0] awaddr_ff, nxt_awaddr;
  logic [15:0]       wdata_ff, nxt_wdata;
  logic [1:0]        wstrb_ff, nxt_wstrb;
  logic              arready_ff, nxt_arready;
  logic              rvalid_ff, nxt_rvalid;
  logic [31:0]       rdata_ff, nxt_rdata;
  logic [1:0]        rresp_ff, nxt_rresp;
  logic [15:0]       cal_mask_ff, nxt_cal_mask;
  cal_config_type    cal_config_ff, nxt_cal_config;
  cal_state_type     cal_state_ff, nxt_cal_state;
  logic              cal_start_ff, nxt_cal_start;
  logic              cal_busy_ff, nxt_cal_busy;
  logic              wr_fire;
  logic [5:0]        wr_idx;
  logic [5:0]        rd_idx;
  logic              wr_hit;
  logic [CMD_N-1:0]  cmd_set;
  logic [CMD_N-1:0]  cmd_done;
  logic [CMD_N-1:0]  cmd_pend;
  logic              reset_finish;

  // --------------------------------------------------------------------------
  // write channel
  // --------------------------------------------------------------------------
  // address and data are latched separately so either may arrive first
  assign wr_fire = aw_got_ff & w_got_ff & ~bvalid_ff;
  assign wr_idx  = awaddr_ff[7:2];

  always_comb begin
    unique case (wr_idx)
      IDX_FLAG_CLEAR, IDX_CAL_MASK, IDX_CAL_CONFIG, IDX_BOARD_RESET,
      IDX_CAL_START, IDX_SCAN_ABORT, IDX_STATUS: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_comb begin
    nxt_aw_got = aw_got_ff;
    nxt_w_got  = w_got_ff;
    nxt_awaddr = awaddr_ff;
    nxt_wdata  = wdata_ff;
    nxt_wstrb  = wstrb_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp  = bresp_ff;
    if (awvalid && awready_ff) begin
      nxt_aw_got = 1'b1;
      nxt_awaddr = awaddr;
    end
    if (wvalid && wready_ff) begin
      nxt_w_got = 1'b1;
      nxt_wdata = wdata[15:0];
      nxt_wstrb = wstrb[1:0];
    end
    if (wr_fire) begin
      nxt_aw_got = 1'b0;
      nxt_w_got  = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp  = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_ff && bready) begin
      nxt_bvalid = 1'b0;
    end
    nxt_awready = ~nxt_aw_got & ~nxt_bvalid;
    nxt_wready  = ~nxt_w_got & ~nxt_bvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_ff  <= 1'b0;
      w_got_ff   <= 1'b0;
      awaddr_ff  <= '0;
      wdata_ff   <= 16'h0000;
      wstrb_ff   <= 2'h0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= RESP_OKAY;
      awready_ff <= 1'b1;
      wready_ff  <= 1'b1;
    end else begin
      aw_got_ff  <= nxt_aw_got;
      w_got_ff   <= nxt_w_got;
      awaddr_ff  <= nxt_awaddr;
      wdata_ff   <= nxt_wdata;
      wstrb_ff   <= nxt_wstrb;
      bvalid_ff  <= nxt_bvalid;
      bresp_ff   <= nxt_bresp;
      awready_ff <= nxt_awready;
      wready_ff  <= nxt_wready;
    end
  end

  // --------------------------------------------------------------------------
  // command bits
  // --------------------------------------------------------------------------
  // only a one in the command bit starts an action; zero writes are ignored
  assign reset_finish = cmd_pend[CMD_BRS] & board_in.reset_done;

  always_comb begin
    cmd_done[CMD_CLR] = ~board_in.data_ready & ~board_in.config_complete; // RQ2
    cmd_done[CMD_BRS] = board_in.reset_done; // RQ10
    cmd_done[CMD_CAL] = (cal_state_ff == CAL_RUN) & board_in.cal_done; // RQ12
    cmd_done[CMD_ABT] = board_in.abort_done; // RQ14
  end

  for (genvar i = 0; i < CMD_N; i++) begin : g_cmd
    assign cmd_set[i] = wr_fire & (wr_idx == CMD_IDX[i]) & wstrb_ff[0] & wdata_ff[CMD_BIT]; // RQ15

    cmd_pending_bit u_bit (
      .aclk    (aclk),
      .aresetn (aresetn),
      .set     (cmd_set[i]),
      .done    (cmd_done[i]),
      .pending (cmd_pend[i])
    );
  end

  assign flag_clear_req  = cmd_pend[CMD_CLR]; // RQ1
  assign board_reset_req = cmd_pend[CMD_BRS]; // RQ9
  assign scan_abort_req  = cmd_pend[CMD_ABT]; // RQ14

  // --------------------------------------------------------------------------
  // calibration setup registers
  // --------------------------------------------------------------------------
  // reserved config bits 15..8 are not stored and read as zero
  always_comb begin
    nxt_cal_mask   = cal_mask_ff;
    nxt_cal_config = cal_config_ff;
    if (wr_fire && wr_idx == IDX_CAL_MASK) begin
      if (wstrb_ff[0]) begin
        nxt_cal_mask[7:0] = wdata_ff[7:0];
      end
      if (wstrb_ff[1]) begin
        nxt_cal_mask[15:8] = wdata_ff[15:8];
      end
    end
    if (wr_fire && wr_idx == IDX_CAL_CONFIG && wstrb_ff[0]) begin
      nxt_cal_config = cal_config_type'(wdata_ff[7:0]); // RQ6 RQ7
    end
    // a finished board reset wins over a write in the same cycle
    if (reset_finish) begin
      nxt_cal_mask   = CAL_MASK_RST; // RQ9
      nxt_cal_config = cal_config_type'(CAL_CONFIG_RST);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cal_mask_ff   <= CAL_MASK_RST; // RQ5
      cal_config_ff <= cal_config_type'(CAL_CONFIG_RST);
    end else begin
      cal_mask_ff   <= nxt_cal_mask;
      cal_config_ff <= nxt_cal_config;
    end
  end

  assign cal_channels = cal_mask_ff; // RQ4
  assign cal_setup    = cal_config_ff; // RQ6 RQ7

  // --------------------------------------------------------------------------
  // calibration sequencer
  // --------------------------------------------------------------------------
  // setup is sampled by the board at cal_start; changing it mid-run is unsafe
  always_comb begin
    nxt_cal_state = cal_state_ff;
    nxt_cal_start = 1'b0;
    unique case (cal_state_ff)
      CAL_IDLE: begin
        if (cmd_pend[CMD_CAL]) begin
          nxt_cal_state = CAL_HELD;
        end
      end
      CAL_HELD: begin
        if (!board_in.scan_active) begin
          nxt_cal_state = CAL_RUN; // RQ13
          nxt_cal_start = 1'b1; // RQ11
        end
      end
      CAL_RUN: begin
        if (board_in.cal_done) begin
          nxt_cal_state = CAL_IDLE; // RQ12
        end
      end
    endcase
    nxt_cal_busy = (nxt_cal_state == CAL_RUN);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cal_state_ff <= CAL_IDLE;
      cal_start_ff <= 1'b0;
      cal_busy_ff  <= 1'b0;
    end else begin
      cal_state_ff <= nxt_cal_state;
      cal_start_ff <= nxt_cal_start;
      cal_busy_ff  <= nxt_cal_busy;
    end
  end

  assign cal_start = cal_start_ff;
  assign cal_busy  = cal_busy_ff;

  // --------------------------------------------------------------------------
  // read channel
  // --------------------------------------------------------------------------
  assign rd_idx = araddr[7:2];

  always_comb begin
    nxt_arready = arready_ff;
    nxt_rvalid  = rvalid_ff;
    nxt_rdata   = rdata_ff;
    nxt_rresp   = rresp_ff;
    if (arvalid && arready_ff) begin
      nxt_rvalid = 1'b1;
      nxt_rresp  = RESP_OKAY;
      nxt_rdata  = 32'h0000_0000;
      unique case (rd_idx)
        IDX_FLAG_CLEAR:  nxt_rdata[CMD_BIT] = cmd_pend[CMD_CLR];
        IDX_CAL_MASK:    nxt_rdata[15:0] = cal_mask_ff;
        IDX_CAL_CONFIG:  nxt_rdata[7:0] = cal_config_ff;
        IDX_BOARD_RESET: nxt_rdata[CMD_BIT] = cmd_pend[CMD_BRS];
        IDX_CAL_START:   nxt_rdata[CMD_BIT] = cmd_pend[CMD_CAL];
        IDX_SCAN_ABORT:  nxt_rdata[CMD_BIT] = cmd_pend[CMD_ABT];
        IDX_STATUS: begin
          nxt_rdata[ST_DATA_READY]  = board_in.data_ready;
          nxt_rdata[ST_CFG_DONE]    = board_in.config_complete;
          nxt_rdata[ST_SCAN_ACTIVE] = board_in.scan_active;
          nxt_rdata[ST_CAL_BUSY]    = cal_busy_ff;
        end
        default: nxt_rresp = RESP_SLVERR;
      endcase
    end else if (rvalid_ff && rready) begin
      nxt_rvalid = 1'b0;
    end
    nxt_arready = ~nxt_rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b1;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h0000_0000;
      rresp_ff   <= RESP_OKAY;
    end else begin
      arready_ff <= nxt_arready;
      rvalid_ff  <= nxt_rvalid;
      rdata_ff   <= nxt_rdata;
      rresp_ff   <= nxt_rresp;
    end
  end

  assign awready = awready_ff;
  assign wready  = wready_ff;
  assign bvalid  = bvalid_ff;
  assign bresp   = bresp_ff;
  assign arready = arready_ff;
  assign rvalid  = rvalid_ff;
  assign rdata   = rdata_ff;
  assign rresp   = rresp_ff;

  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  a_flag_clear_set: assert property (@(posedge aclk) disable iff (!aresetn) // RQ1
    cmd_set[CMD_CLR] |=> flag_clear_req)
    else $error("flag clear write did not raise request");

  a_flag_clear_hold: assert property (@(posedge aclk) disable iff (!aresetn) // RQ2
    flag_clear_req && (board_in.data_ready || board_in.config_complete) |=> flag_clear_req)
    else $error("flag clear dropped while a flag is still set");

  a_flag_clear_end: assert property (@(posedge aclk) disable iff (!aresetn) // RQ2
    flag_clear_req && !board_in.data_ready && !board_in.config_complete && !cmd_set[CMD_CLR]
    |=> !flag_clear_req)
    else $error("flag clear stayed set after both flags cleared");

  a_reset_restore: assert property (@(posedge aclk) disable iff (!aresetn) // RQ9
    board_reset_req && board_in.reset_done |=> cal_channels == 16'h0000 && cal_setup == 8'h00)
    else $error("setup registers not restored after board reset");

  a_reset_wait: assert property (@(posedge aclk) disable iff (!aresetn) // RQ10
    board_reset_req && !board_in.reset_done |=> board_reset_req)
    else $error("board reset bit cleared before reset done");

  a_cal_holdoff: assert property (@(posedge aclk) disable iff (!aresetn) // RQ13
    cal_state_ff == CAL_HELD && board_in.scan_active |=> !cal_start && !cal_busy)
    else $error("calibration started during active scan");

  a_cal_launch: assert property (@(posedge aclk) disable iff (!aresetn) // RQ11
    cmd_pend[CMD_CAL] && cal_state_ff == CAL_IDLE ##1 !board_in.scan_active
    |=> cal_start && cal_busy ##1 !cal_start)
    else $error("calibration did not start as a single pulse");

  a_cal_finish: assert property (@(posedge aclk) disable iff (!aresetn) // RQ12
    cal_busy && board_in.cal_done && !cmd_set[CMD_CAL] |=> !cmd_pend[CMD_CAL] && !cal_busy)
    else $error("calibration bit not cleared at completion");

  a_abort_clear: assert property (@(posedge aclk) disable iff (!aresetn) // RQ14
    scan_abort_req && !board_in.abort_done |=> scan_abort_req)
    else $error("abort bit cleared before scan aborted");

  a_zero_write: assert property (@(posedge aclk) disable iff (!aresetn) // RQ15
    wr_fire && wr_idx == IDX_SCAN_ABORT && !wdata_ff[CMD_BIT] && !scan_abort_req
    |=> !scan_abort_req)
    else $error("zero write started an abort");

endmodule

// *** verification/board_model.sv ***
// board-side responder: raises status flags and answers command requests after a set delay
`timescale 1ns/1ps
module board_model
  import adc_cmd_pkg::*;
(
  // clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // bench control
  input  wire logic [3:0] delay,
  input  wire logic       set_flags,
  input  wire logic       start_scan,
  // requests from the register bank
  input  wire logic       flag_clear_req,
  input  wire logic       board_reset_req,
  input  wire logic       scan_abort_req,
  input  wire logic       cal_busy,
  // status and completions
  output board_event_type board_in
);
  // ------------------------------------------------------------------
  // request timers: slot order clear, reset, abort, calibration
  // ------------------------------------------------------------------
  logic [3:0] req;
  logic [3:0] done;
  logic [4:0] cnt_ff [4];
  logic [1:0] flags_ff;
  logic       scan_ff;

  assign req = {cal_busy, scan_abort_req, board_reset_req, flag_clear_req};

  // done is level for one cycle only, so a lingering request never sees a second one
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      done[i] = req[i] && (cnt_ff[i] == {1'b0, delay});
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 4; i++) begin
        cnt_ff[i] <= 5'h00;
      end
      flags_ff <= 2'h0;
      scan_ff  <= 1'b0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        cnt_ff[i] <= req[i] ? cnt_ff[i] + {4'h0, ~&cnt_ff[i]} : 5'h00;
      end
      if (set_flags) begin
        flags_ff <= 2'h3;
      end else if (done[0]) begin
        flags_ff <= 2'h0;
      end
      if (start_scan) begin
        scan_ff <= 1'b1;
      end else if (done[2]) begin
        scan_ff <= 1'b0;
      end
    end
  end

  assign board_in = '{data_ready: flags_ff[1], config_complete: flags_ff[0], scan_active: scan_ff,
                      reset_done: done[1], cal_done: done[3], abort_done: done[2]};
endmodule

// *** verification/tb_top.sv ***
// self-checking bench for the command register bank: bus tasks and command sequences
`timescale 1ns/1ps
module tb_top;
  import adc_cmd_pkg::*;

  // ------------------------------------------------------------------
  // signals
  // ------------------------------------------------------------------
  logic            aclk, aresetn;
  logic [7:0]      awaddr, araddr;
  logic            awvalid, awready, wvalid, wready, bvalid, bready;
  logic            arvalid, arready, rvalid, rready;
  logic [31:0]     wdata, rdata;
  logic [3:0]      wstrb, delay;
  logic [1:0]      bresp, rresp;
  board_event_type board_in;
  logic            flag_clear_req, board_reset_req, scan_abort_req, cal_start, cal_busy;
  logic [15:0]     cal_channels;
  cal_config_type  cal_setup;
  logic            set_flags, start_scan;
  int              n_mismatch, comparisons, cycles, cal_pulses, n;
  logic [7:0]      cfg [2] = '{8'h5a, 8'ha5};
  logic [3:0]      dl [2] = '{4'h0, 4'h6};
  logic [5:0]      dflt [7] = '{IDX_FLAG_CLEAR, IDX_CAL_MASK, IDX_CAL_CONFIG, IDX_BOARD_RESET,
                                IDX_CAL_START, IDX_SCAN_ABORT, IDX_STATUS};

  adc_board_command_registers i_adc_board_command_registers (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
    .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .board_in,
    .flag_clear_req, .board_reset_req, .scan_abort_req, .cal_start, .cal_busy, .cal_channels,
    .cal_setup);

  board_model i_board_model (
    .aclk, .aresetn, .delay, .set_flags, .start_scan, .flag_clear_req, .board_reset_req,
    .scan_abort_req, .cal_busy, .board_in);

  // ------------------------------------------------------------------
  // checking and bus tasks
  // ------------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // a leading edge keeps a released strobe from being raised again in the same step
  task automatic wr(input logic [5:0] idx, input logic [31:0] d, input logic [1:0] re);
    logic aw;
    logic w;
    @(posedge aclk);
    aw = 1'b1;
    w = 1'b1;
    awaddr <= {idx, 2'b00};
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    while (aw || w) begin
      @(posedge aclk);
      if (aw && awready === 1'b1) begin
        aw = 1'b0;
        awvalid <= 1'b0;
      end
      if (w && wready === 1'b1) begin
        w = 1'b0;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("write resp", {30'h0, re}, {30'h0, bresp});
  endtask

  task automatic rd_chk(input string nm, input logic [5:0] idx, input logic [31:0] e, input logic [1:0] re);
    @(posedge aclk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(nm, e, rdata);
    chk({nm, " resp"}, {30'h0, re}, {30'h0, rresp});
  endtask

  // bounded wait for a pending request to drop: 0 clear, 1 reset, 2 abort, 3 calibration
  task automatic wait_low(input int s);
    logic v;
    for (int k = 0; k < 60; k++) begin
      v = (s == 0) ? flag_clear_req : (s == 1) ? board_reset_req : (s == 2) ? scan_abort_req : cal_busy;
      if (v === 1'b0) break;
      @(posedge aclk);
    end
    chk("request drop", 32'h0, {31'h0, v});
  endtask

  task automatic finish_test();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ------------------------------------------------------------------
  // clock, watchdog, launch counter
  // ------------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cal_start === 1'b1)
      cal_pulses <= cal_pulses + 1;
    if (cycles == 3000) begin
      n_mismatch = n_mismatch + 1;
      finish_test();
    end
  end

  // ------------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------------
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, set_flags, start_scan} = 8'h00;
    {awaddr, araddr, wdata, wstrb, delay} = {8'h00, 8'h00, 32'h0000_0000, 4'hf, 4'h6};
    {n_mismatch, comparisons, cycles, cal_pulses} = {32'h0, 32'h0, 32'h0, 32'h0};
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    foreach (dflt[i]) rd_chk("reset value", dflt[i], 32'h0, RESP_OKAY);
    wr(IDX_CAL_MASK, 32'h0000_a5c3, RESP_OKAY);
    rd_chk("mask", IDX_CAL_MASK, 32'h0000_a5c3, RESP_OKAY);
    chk("channels", 32'h0000_a5c3, {16'h0, cal_channels});
    foreach (cfg[i]) begin
      wr(IDX_CAL_CONFIG, {24'h0, cfg[i]}, RESP_OKAY);
      rd_chk("config", IDX_CAL_CONFIG, {24'h0, cfg[i]}, RESP_OKAY);
      chk("cutoff", {28'h0, cfg[i][7:4]}, {28'h0, cal_setup.cutoff});
      chk("range", {28'h0, cfg[i][3:0]}, {28'h0, cal_setup.range});
    end
    wr(IDX_CAL_CONFIG, 32'h0000_001f, RESP_OKAY);
    chk("no filter cutoff", 32'h1, {28'h0, cal_setup.cutoff});
    // flag clear, prompt and slow board
    foreach (dl[k]) begin
      delay <= dl[k];
      set_flags <= 1'b1;
      @(posedge aclk);
      set_flags <= 1'b0;
      rd_chk("flags up", IDX_STATUS, 32'h3, RESP_OKAY);
      wr(IDX_FLAG_CLEAR, 32'h1, RESP_OKAY);
      if (dl[k] != 4'h0)
        rd_chk("clear pending", IDX_FLAG_CLEAR, 32'h1, RESP_OKAY);
      wait_low(0);
      chk("flags at clear end", 32'h0, {30'h0, board_in.data_ready, board_in.config_complete});
      rd_chk("clear bit", IDX_FLAG_CLEAR, 32'h0, RESP_OKAY);
      rd_chk("flags down", IDX_STATUS, 32'h0, RESP_OKAY);
    end
    // writing zero starts nothing
    wr(IDX_CAL_START, 32'h0, RESP_OKAY);
    wr(IDX_SCAN_ABORT, 32'h0, RESP_OKAY);
    repeat (4) @(posedge aclk);
    chk("idle launches", 32'h0, 32'(cal_pulses));
    chk("idle abort", 32'h0, {31'h0, scan_abort_req});
    // calibration held by an active scan until aborted
    start_scan <= 1'b1;
    @(posedge aclk);
    start_scan <= 1'b0;
    wr(IDX_CAL_START, 32'h1, RESP_OKAY);
    repeat (20) @(posedge aclk);
    chk("held launches", 32'h0, 32'(cal_pulses));
    rd_chk("cal pending", IDX_CAL_START, 32'h1, RESP_OKAY);
    wr(IDX_SCAN_ABORT, 32'h1, RESP_OKAY);
    wait_low(2);
    // launch follows the abort by one cycle, so busy is read before the board finishes
    n = 0;
    while (cal_pulses == 0 && n++ < 40) @(posedge aclk);
    chk("cal mask", 32'h0000_a5c3, {16'h0, cal_channels});
    rd_chk("busy status", IDX_STATUS, 32'h8, RESP_OKAY);
    rd_chk("abort bit", IDX_SCAN_ABORT, 32'h0, RESP_OKAY);
    wait_low(3);
    chk("launches", 32'h1, 32'(cal_pulses));
    rd_chk("cal bit", IDX_CAL_START, 32'h0, RESP_OKAY);
    // no scan running: the command launches without any hold-off
    wr(IDX_CAL_START, 32'h1, RESP_OKAY);
    repeat (4) @(posedge aclk);
    wait_low(3);
    chk("free launches", 32'h2, 32'(cal_pulses));
    rd_chk("cal bit again", IDX_CAL_START, 32'h0, RESP_OKAY);
    // board reset restores the setup
    wr(IDX_BOARD_RESET, 32'h1, RESP_OKAY);
    rd_chk("reset pending", IDX_BOARD_RESET, 32'h1, RESP_OKAY);
    wait_low(1);
    rd_chk("reset bit", IDX_BOARD_RESET, 32'h0, RESP_OKAY);
    rd_chk("mask after reset", IDX_CAL_MASK, 32'h0, RESP_OKAY);
    rd_chk("config after reset", IDX_CAL_CONFIG, 32'h0, RESP_OKAY);
    chk("setup after reset", 32'h0, {8'h0, cal_channels, cal_setup});
    // unmapped place
    wr(6'h3f, 32'h1, RESP_SLVERR);
    rd_chk("unmapped", 6'h3f, 32'h0, RESP_SLVERR);
    finish_test();
  end
endmodule
